// *** hdl/serial_link_if.sv ***
`timescale 1ns/1ps
interface serial_link_if;
    logic sel_n;        // host chip select, active low
    logic sclk;         // host shift clock
    logic serial_in;    // host to device data
    logic serial_out_o; // device data out
    logic serial_out_oe;// device drives serial_out
    logic irq_o;        // interrupt pin drive value
    logic irq_oe;       // interrupt pin enable
    wire  serial_out;
    wire  irq_line;
    assign serial_out = serial_out_oe ? serial_out_o : 1'b1;
    assign irq_line   = irq_oe ? irq_o : 1'b1;
    modport device (input sel_n, input sclk, input serial_in,
                    output serial_out_o, output serial_out_oe, output irq_o, output irq_oe);
    modport host   (output sel_n, output sclk, output serial_in,
                    input serial_out, input irq_line);
endinterface : serial_link_if

// *** hdl/serial_port_device.sv ***
`timescale 1ns/1ps
// Behaviour
// - any unmasked pending source raises interrupt
// - config bits 3:2 pick drive, polarity
// - select low enables port, high ignored
// - host gives fresh select fall per access
// - host holds select low whole access
// - pins act as clock, in, out
// - inputs shifted on rising shift clock
// - output changes on falling shift clock
module serial_port_device
    import serial_port_pkg::*;
#(
    parameter int N_SRC = 8
) (
    input  wire logic              i_mclk,      // core clock
    input  wire logic              i_rst_n,     // sync reset, active low
    serial_link_if.device          link,        // pins toward host
    input  wire logic [N_SRC-1:0]  i_irq_src,   // pending sources, levels
    input  wire logic [N_SRC-1:0]  i_irq_mask,  // 1 masks a source
    input  wire logic [DATA_W-1:0] i_rd_data,   // read data for o_addr
    output logic [ADDR_W-1:0]      o_addr,      // access address
    output logic [DATA_W-1:0]      o_wr_data,   // write data
    output logic                   o_wr_stb,    // one-cycle write pulse
    output logic                   o_rd_stb,    // one-cycle read request
    output logic [DATA_W-1:0]      o_gcfg       // global_config_reg copy
);
    logic [1:0] sel_s_q, sclk_s_q, sin_s_q;
    logic       sclk_last_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [FRAME_BITS-1:0] sh_q;
    logic       is_rd_q;
    logic [DATA_W-1:0] rd_sh_q;
    logic       sdo_q, sdo_oe_q;
    logic       irq_q, irq_oe_q;
    logic [DATA_W-1:0] global_config_reg_q;
    logic       rise, fall, active;

    // two-flop synchronisers; only the second stage is read
    always_ff @(posedge i_mclk) begin
        sel_s_q  <= {sel_s_q[0], link.sel_n};
        sclk_s_q <= {sclk_s_q[0], link.sclk};
        sin_s_q  <= {sin_s_q[0], link.serial_in};
    end

    always_ff @(posedge i_mclk) begin
        sclk_last_q <= i_rst_n ? sclk_s_q[1] : 1'b0;
    end

    assign active = ~sel_s_q[1];
    assign rise   = active & sclk_s_q[1] & ~sclk_last_q;
    assign fall   = active & ~sclk_s_q[1] & sclk_last_q;

    // frame shifter; a select high resets the count so each access starts fresh
    always_ff @(posedge i_mclk) begin
        o_wr_stb <= 1'b0;
        o_rd_stb <= 1'b0;
        if (!i_rst_n || !active) begin
            cnt_q   <= '0;
            sh_q    <= '0;
            is_rd_q <= 1'b0;
        end else if (rise && cnt_q < CNT_W'(FRAME_BITS)) begin
            sh_q  <= {sh_q[FRAME_BITS-2:0], sin_s_q[1]};
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == '0)
                is_rd_q <= sin_s_q[1];
            if (cnt_q == CNT_W'(ADDR_W)) begin
                o_addr   <= {sh_q[ADDR_W-2:0], sin_s_q[1]};
                o_rd_stb <= is_rd_q;
            end
            if (cnt_q == CNT_W'(FRAME_BITS - 1) && !is_rd_q) begin
                o_wr_data <= {sh_q[DATA_W-2:0], sin_s_q[1]};
                o_wr_stb  <= 1'b1;
            end
        end
    end

    // config register written through the port at its own address
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n)
            global_config_reg_q <= GLOBAL_CONFIG_RESET;
        else if (o_wr_stb && {1'b0, o_addr} == GLOBAL_CONFIG_ADDR)
            global_config_reg_q <= o_wr_data;
    end

    always_ff @(posedge i_mclk) begin
        o_gcfg <= i_rst_n ? global_config_reg_q : GLOBAL_CONFIG_RESET;
    end

    // read data: loaded after address, shifted out on falling edges
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !active) begin
            rd_sh_q  <= '0;
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (fall && is_rd_q && cnt_q == CNT_W'(ADDR_W + 1)) begin
            rd_sh_q  <= {i_rd_data[DATA_W-2:0], 1'b0};
            sdo_q    <= i_rd_data[DATA_W-1];
            sdo_oe_q <= 1'b1;
        end else if (fall && sdo_oe_q) begin
            if (cnt_q == CNT_W'(FRAME_BITS))
                sdo_oe_q <= 1'b0;
            sdo_q   <= rd_sh_q[DATA_W-1];
            rd_sh_q <= {rd_sh_q[DATA_W-2:0], 1'b0};
        end
    end

    // 00 open drain low, 01 open drain high, 10 push-pull low, 11 push-pull high
    always_ff @(posedge i_mclk) begin
        logic pend, lvl;
        pend = |(i_irq_src & ~i_irq_mask);
        lvl  = global_config_reg_q[IRQ_CFG_LSB] ? pend : ~pend;
        if (!i_rst_n) begin
            irq_q    <= 1'b1;
            irq_oe_q <= 1'b0;
        end else if (global_config_reg_q[IRQ_CFG_MSB]) begin
            irq_q    <= lvl;
            irq_oe_q <= 1'b1;
        end else begin
            irq_q    <= lvl;
            irq_oe_q <= pend;
        end
    end

    assign link.serial_out_o  = sdo_q;
    assign link.serial_out_oe = sdo_oe_q;
    assign link.irq_o         = irq_q;
    assign link.irq_oe        = irq_oe_q;
endmodule : serial_port_device

// *** hdl/serial_port_host.sv ***
`timescale 1ns/1ps
module serial_port_host
    import serial_port_pkg::*;
(
    input  wire logic              i_mclk,     // core clock
    input  wire logic              i_rst_n,    // sync reset, active low
    serial_link_if.host            link,       // pins toward device
    input  wire logic              i_start,    // start one access
    input  wire logic              i_read,     // 1 read, 0 write
    input  wire logic [ADDR_W-1:0] i_addr,     // address
    input  wire logic [DATA_W-1:0] i_wdata,    // write data
    output logic                   o_busy,     // access in progress
    output logic                   o_done,     // one-cycle completion
    output logic [DATA_W-1:0]      o_rdata,    // read data
    output logic                   o_irq       // synchronised irq line, raw
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_GAP  = 2'b11
    } state_t;
    state_t state_q;
    logic [HALF_W-1:0]     tmr_q;
    logic [CNT_W-1:0]      bit_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic [DATA_W-1:0]     rx_q;
    logic [1:0]            sdo_s_q, irq_s_q;
    logic                  sel_n_q, sclk_q;

    always_ff @(posedge i_mclk) begin
        sdo_s_q <= {sdo_s_q[0], link.serial_out};
        irq_s_q <= {irq_s_q[0], link.irq_line};
        o_irq   <= i_rst_n ? irq_s_q[1] : 1'b0;
    end

    // divider-driven shift clock; select dropped fresh for each access
    always_ff @(posedge i_mclk) begin
        o_done <= 1'b0;
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            sel_n_q <= 1'b1;
            sclk_q  <= 1'b0;
            tmr_q   <= '0;
            bit_q   <= '0;
            tx_q    <= '0;
            rx_q    <= '0;
            o_busy  <= 1'b0;
            o_rdata <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (i_start) begin
                        sel_n_q <= 1'b0;
                        tx_q    <= {i_read, i_addr, i_wdata};
                        bit_q   <= '0;
                        tmr_q   <= HALF_W'(SCLK_HALF_CYCLES);
                        o_busy  <= 1'b1;
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (tmr_q == '0) begin
                        sclk_q  <= 1'b1;
                        tmr_q   <= HALF_W'(SCLK_HALF_CYCLES);
                        rx_q    <= {rx_q[DATA_W-2:0], sdo_s_q[1]};
                        state_q <= ST_HIGH;
                    end else
                        tmr_q <= tmr_q - 1'b1;
                end
                ST_HIGH: begin
                    if (tmr_q == '0) begin
                        sclk_q <= 1'b0;
                        tmr_q  <= HALF_W'(SCLK_HALF_CYCLES);
                        tx_q   <= {tx_q[FRAME_BITS-2:0], 1'b0};
                        if (bit_q == CNT_W'(FRAME_BITS - 1)) begin
                            sel_n_q <= 1'b1;
                            state_q <= ST_GAP;
                        end else begin
                            bit_q   <= bit_q + 1'b1;
                            state_q <= ST_LOW;
                        end
                    end else
                        tmr_q <= tmr_q - 1'b1;
                end
                ST_GAP: begin
                    if (tmr_q == HALF_W'(SCLK_HALF_CYCLES - SEL_GAP_CYCLES)) begin
                        o_busy  <= 1'b0;
                        o_done  <= 1'b1;
                        o_rdata <= rx_q;
                        state_q <= ST_IDLE;
                    end else
                        tmr_q <= tmr_q - 1'b1;
                end
            endcase
        end
    end

    assign link.sel_n     = sel_n_q;
    assign link.sclk      = sclk_q;
    assign link.serial_in = tx_q[FRAME_BITS-1];
endmodule : serial_port_host

// *** hdl/serial_port_pkg.sv ***
package serial_port_pkg;
    // frame layout: one read/write flag, address, then data
    localparam int ADDR_W     = 7;
    localparam int DATA_W     = 8;
    localparam int FRAME_BITS = 1 + ADDR_W + DATA_W;
    localparam int CNT_W      = 5;
    // interrupt pin field of global_config_reg
    localparam int IRQ_CFG_LSB = 2;
    localparam int IRQ_CFG_MSB = 3;
    localparam logic [7:0] GLOBAL_CONFIG_ADDR  = 8'h00;
    localparam logic [7:0] GLOBAL_CONFIG_RESET = 8'h00;
    // host shift clock half period, in i_mclk cycles
    localparam int SCLK_HALF_NS     = 60;
    localparam int MCLK_PERIOD_NS   = 5;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int SEL_GAP_CYCLES   = 4;
    localparam int HALF_W           = 8;
endpackage : serial_port_pkg

// *** test/serial_port_assertions.sv ***
`timescale 1ns/1ps
// watches the link between host and device ends
module serial_port_assertions (
    input wire logic i_mclk,        // core clock
    input wire logic i_rst_n,       // sync reset, active low
    input wire logic sel_n,         // chip select
    input wire logic sclk,          // shift clock
    input wire logic serial_in,     // host data
    input wire logic serial_out_o,  // device data
    input wire logic serial_out_oe  // device enable
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // a frame opens with the clock idle, frames are parted by a gap
    sequence idle_clk; (!sclk) [*8]; endsequence
    sequence sel_gap; sel_n [*4]; endsequence
    // past depth covers the device's synchroniser lag
    AST_SEL_REL: assert property (sel_n && $past(sel_n, 8) |-> !serial_out_oe)
        else $error("data out driven with select high");
    AST_OUT_FALL: assert property (serial_out_oe && $changed(serial_out_o) |-> !sclk)
        else $error("data out moved while clock high");
    AST_OE_START: assert property ($rose(serial_out_oe) |-> !sclk)
        else $error("data out enabled off a falling edge");
    AST_OE_END: assert property ($fell(serial_out_oe) |-> !sclk)
        else $error("data out released off a falling edge");
    AST_CLK_SEL: assert property (sclk |-> !sel_n)
        else $error("clock high with select high");
    AST_SEL_GAP: assert property ($rose(sel_n) |-> sel_gap)
        else $error("select gap too short");
    AST_FRAME_START: assert property ($fell(sel_n) |-> idle_clk)
        else $error("clock not idle at frame start");
    AST_IN_STABLE: assert property ($rose(sclk) |-> $stable(serial_in))
        else $error("data in moved at clock rise");
endmodule : serial_port_assertions

// *** test/test_serial_host_port_with_irq.sv ***
`timescale 1ns/1ps
module test_serial_host_port_with_irq;
    import serial_port_pkg::*;
    logic              i_mclk, i_rst_n, start, rd, busy, done, irq;
    logic              wr_stb, rd_stb, wr_stb_b, rd_stb_b;
    logic [ADDR_W-1:0] addr, ea, o_addr, o_addr_b;
    logic [DATA_W-1:0] wdata, ed, o_rdata, o_wr_data, o_wr_data_b, o_gcfg, src, mask;
    logic [DATA_W-1:0] mem [128];
    integer            num_errors = 0, cmp_count = 0, wr_n = 0, rd_n = 0, bad_n = 0, k, m, j;
    serial_link_if lk ();
    serial_link_if lk_b ();
    serial_port_device u_serial_port_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(lk),
        .i_irq_src(src), .i_irq_mask(mask), .i_rd_data(mem[o_addr]), .o_addr(o_addr),
        .o_wr_data(o_wr_data), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb), .o_gcfg(o_gcfg));
    // second device faces the bench's own, rule-breaking driver
    serial_port_device u_serial_port_device_b (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(lk_b),
        .i_irq_src(src), .i_irq_mask(mask), .i_rd_data(8'h00), .o_addr(o_addr_b),
        .o_wr_data(o_wr_data_b), .o_wr_stb(wr_stb_b), .o_rd_stb(rd_stb_b), .o_gcfg());
    serial_port_host u_serial_port_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(lk),
        .i_start(start), .i_read(rd), .i_addr(addr), .i_wdata(wdata), .o_busy(busy),
        .o_done(done), .o_rdata(o_rdata), .o_irq(irq));
    serial_port_assertions u_serial_port_assertions (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .sel_n(lk.sel_n), .sclk(lk.sclk), .serial_in(lk.serial_in),
        .serial_out_o(lk.serial_out_o), .serial_out_oe(lk.serial_out_oe));
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    task automatic step;
        @(posedge i_mclk);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // one access through the host end; busy wait first, start is ignored then
    task automatic acc(input logic r, input logic [6:0] a, input logic [7:0] d);
        integer n;
        integer c;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin step(); n++; end
        if (n == 100) begin num_errors++; test_done(); end
        c = r ? rd_n : wr_n;
        ea = a;
        ed = d;
        start = 1'b1;
        rd = r;
        addr = a;
        wdata = d;
        step();
        start = 1'b0;
        chk(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 3000) begin step(); n++; end
        if (n == 3000) begin num_errors++; test_done(); end
        chk(r ? rd_n : wr_n, c + 1);
        chk(busy, 1'b0);
        if (r) chk(o_rdata, mem[a]);
    endtask : acc
    task automatic irq_chk(input logic [1:0] md, input int s);
        logic p;
        logic e;
        src = 8'($urandom);
        mask = (s == 0) ? 8'hFF : 8'($urandom);
        repeat (8) step();
        p = |(src & ~mask);
        e = md[1] ? (md[0] ? p : !p) : (p ? md[0] : 1'b1);
        chk(lk.irq_line, e);
        chk(irq, e);
    endtask : irq_chk
    // link clock of 125 ns, idle low outside frames
    task automatic frame_b(input logic [15:0] f, input int n, input logic s);
        integer i;
        lk_b.sel_n = s;
        #100;
        for (i = 0; i < n; i++) begin
            lk_b.serial_in = f[15-i];
            #62.5 lk_b.sclk = 1'b1;
            #62.5 lk_b.sclk = 1'b0;
        end
        #100 lk_b.sel_n = 1'b1;
        lk_b.serial_in = ~lk_b.serial_in;
        #300;
    endtask : frame_b
    // model side of the user ports: strobes checked, writes land in mem
    always @(negedge i_mclk) begin
        if (wr_stb === 1'b1) begin
            chk(o_addr, ea);
            chk(o_wr_data, ed);
            mem[o_addr] = o_wr_data;
            wr_n++;
        end
        if (rd_stb === 1'b1) begin
            chk(o_addr, ea);
            rd_n++;
        end
        if (wr_stb_b === 1'b1 || rd_stb_b === 1'b1) bad_n++;
    end
    initial begin
        void'($urandom(32'hA56E7836));
        {i_rst_n, start, rd, addr, wdata, src, mask, ea, ed} = '0;
        {lk_b.sel_n, lk_b.sclk, lk_b.serial_in} = 3'h4;
        for (k = 0; k < 128; k++) mem[k] = 8'($urandom);
        repeat (12) step();
        i_rst_n = 1'b1;
        for (k = 0; k < 12; k++) acc(k[0], 7'(1 + $urandom % 127), 8'($urandom));
        for (m = 0; m < 4; m++) begin
            acc(1'b0, 7'(GLOBAL_CONFIG_ADDR), {4'h0, 2'(m), 2'h0});
            chk(o_gcfg, {4'h0, 2'(m), 2'h0});
            for (j = 0; j < 3; j++) irq_chk(2'(m), j);
        end
        frame_b(16'h5AA5, 16, 1'b1);
        frame_b(16'h2A5C, 10, 1'b0);
        chk(bad_n, 0);
        frame_b({1'b0, 7'h35, 8'hC6}, 16, 1'b0);
        chk(bad_n, 1);
        chk(o_addr_b, 7'h35);
        chk(o_wr_data_b, 8'hC6);
        test_done();
    end
endmodule : test_serial_host_port_with_irq
